//--- hw/bcc_pkg.sv
// package: register map, field positions and fixed values of the command/class block
package bcc_pkg;
   // ***************************************************************
   // register offsets (byte addresses)
   // ***************************************************************
   localparam logic [11:0] CMD_STATUS_OFS = 12'h004;
   localparam logic [11:0] CLASS_CODE_OFS = 12'h008;
   localparam logic [11:0] DEV_CTRL_OFS = 12'h010;
   localparam logic [11:0] IRQ_STATUS_OFS = 12'h014;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h018;
   // ***************************************************************
   // command bit positions
   // ***************************************************************
   localparam int IO_SPACE_BIT = 0;
   localparam int MEM_SPACE_BIT = 1;
   localparam int BUS_MASTER_BIT = 2;
   localparam int SPECIAL_CYC_BIT = 3;
   localparam int WR_INVAL_BIT = 4;
   localparam int PALETTE_BIT = 5;
   localparam int PARITY_RESP_BIT = 6;
   localparam int WAIT_CYC_BIT = 7;
   localparam int SYS_ERR_BIT = 8;
   localparam int FAST_B2B_BIT = 9;
   localparam int IRQ_DIS_BIT = 10;
   localparam int MDPE_BIT = 24;
   // device control: nonfatal and fatal reporting enables
   localparam int DC_NONFATAL_BIT = 1;
   localparam int DC_FATAL_BIT = 2;
   // ***************************************************************
   // fixed class fields and reset values
   // ***************************************************************
   localparam logic [7:0] BASE_CLASS = 8'h06;
   localparam logic [7:0] SUB_CLASS = 8'h04;
   localparam logic [7:0] INTERFACE_A = 8'h00;
   localparam logic [7:0] REVISION_DEFAULT = 8'h5A; // arbitrary value
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // ***************************************************************
   // interrupt status bits
   // ***************************************************************
   localparam int EV_MDPE = 0;
   localparam int EV_UR = 1;
   localparam int EV_ERR_MSG = 2;
   localparam int EV_COUNT = 3;
   // request kinds arriving from the link
   typedef enum logic [1:0] {
      BCC_REQ_MEM,
      BCC_REQ_IO,
      BCC_REQ_OTHER
   } bcc_req_kind_t;
endpackage : bcc_pkg

//--- hw/bcc_regs.sv
// command/class register bank of the bridge with APB slave and interrupt
// Behaviour
// [RULE1] interrupt disable bit reads zero always
// [RULE2] bits 9,7,5,3 read zero always
// [RULE3] system error enable gates own error reporting
// [RULE4] forward secondary SERR as error messages
// [RULE5] reporting enabled by command OR device control
// [RULE6] parity response gates master data parity flag
// [RULE7] write invalidate reads zero, never promotes
// [RULE8] bus master enable gates upstream initiation
// [RULE9] memory disabled answers unsupported request
// [RULE10] memory enabled forwards memory requests
// [RULE11] io disabled answers unsupported, else forward
// [RULE12] base class reads 0x06
// [RULE13] sub class reads 0x04
// [RULE14] programming interface reads 0x00
// [RULE15] revision byte fixed, not writable
// [RULE16] parity flag set on poison, write-one clears
// [RULE17] read-only writes ignored, fixed reads
//
// Chosen here: the APB slave port.
module bcc_regs
   import bcc_pkg::*;
#(
   parameter logic [7:0] REVISION = REVISION_DEFAULT
) (
   input wire logic CLK_SYS_IN,
   input wire logic NRST_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // requests from the link
   input wire logic REQ_VALID_IN,
   input wire bcc_req_kind_t REQ_KIND_IN,
   output logic REQ_FWD_OUT,
   output logic REQ_UR_OUT,
   // error sources
   input wire logic POISON_CPL_IN,
   input wire logic POISON_WR_IN,
   input wire logic OWN_NONFATAL_IN,
   input wire logic OWN_FATAL_IN,
   input wire logic SEC_SERR_IN,
   output logic ERR_NONFATAL_OUT,
   output logic ERR_FATAL_OUT,
   // upstream initiation
   input wire logic MST_REQ_IN,
   output logic MST_GRANT_OUT,
   output logic WR_INVAL_OUT,
   output logic IRQ_OUT
);
   // ***************************************************************
   // storage
   // ***************************************************************
   logic io_space_en;
   logic memory_space_en;
   logic bus_master_en;
   logic parity_response_en;
   logic system_error_report_en;
   logic [2:0] dev_ctrl;
   logic [EV_COUNT-1:0] irq_mask;
   logic [EV_COUNT-1:0] irq_stat;
   logic [EV_COUNT-1:0] ev_set;
   logic master_data_parity_error;
   logic wr_acc;
   logic rd_acc;
   logic hit;
   logic [31:0] next_rdata;
   logic [31:0] cmd_word;
   logic report_nonfatal;
   logic report_fatal;
   logic irq_disable_bit;
   logic fast_b2b_enable;
   logic palette_snoop;
   logic special_cycle_en;
   logic wait_cycle_en;
   logic write_invalidate_en;

   // access strobes: slave answers in the first access cycle
   assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign rd_acc = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
   assign PREADY_OUT = 1'b1;

   // fixed-zero command bits; no storage so writes cannot stick
   assign irq_disable_bit = 1'b0;   // [RULE1]
   assign fast_b2b_enable = 1'b0;   // [RULE2]
   assign palette_snoop = 1'b0;     // [RULE2]
   assign special_cycle_en = 1'b0;  // [RULE2]
   assign wait_cycle_en = 1'b0;     // [RULE2]
   assign write_invalidate_en = 1'b0; // [RULE7]
   // writes are never promoted since the enable is frozen low
   assign WR_INVAL_OUT = write_invalidate_en; // [RULE7]

   // ***************************************************************
   // command register, writable bits only
   // ***************************************************************
   always_ff @(posedge CLK_SYS_IN) begin
      if (!NRST_IN) begin
         io_space_en <= 1'b0;
         memory_space_en <= 1'b0;
         bus_master_en <= 1'b0;
         parity_response_en <= 1'b0;
         system_error_report_en <= 1'b0;
      end else if (wr_acc && PADDR_IN == CMD_STATUS_OFS) begin
         io_space_en <= PWDATA_IN[IO_SPACE_BIT];           // [RULE11]
         memory_space_en <= PWDATA_IN[MEM_SPACE_BIT];      // [RULE9]
         bus_master_en <= PWDATA_IN[BUS_MASTER_BIT];       // [RULE8]
         parity_response_en <= PWDATA_IN[PARITY_RESP_BIT]; // [RULE6]
         system_error_report_en <= PWDATA_IN[SYS_ERR_BIT]; // [RULE3]
      end
   end

   // device control and interrupt mask
   always_ff @(posedge CLK_SYS_IN) begin
      if (!NRST_IN) begin
         dev_ctrl <= 3'h0;
         irq_mask <= '0;
      end else if (wr_acc && PADDR_IN == DEV_CTRL_OFS) begin
         dev_ctrl <= PWDATA_IN[2:0];
      end else if (wr_acc && PADDR_IN == IRQ_MASK_OFS) begin
         irq_mask <= PWDATA_IN[EV_COUNT-1:0];
      end
   end

   // ***************************************************************
   // master data parity error flag
   // ***************************************************************
   // only counts while parity response is enabled
   bcc_w1c_bit u_mdpe (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .set_in(parity_response_en && (POISON_CPL_IN || POISON_WR_IN)),
      .clr_in(wr_acc && PADDR_IN == CMD_STATUS_OFS
              && PWDATA_IN[MDPE_BIT]),
      .flag_out(master_data_parity_error)  // [RULE16] [RULE6]
   );

   // ***************************************************************
   // request gating
   // ***************************************************************
   bcc_req_gate u_gate (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .valid_in(REQ_VALID_IN),
      .kind_in(REQ_KIND_IN),
      .mem_en_in(memory_space_en),  // [RULE9] [RULE10]
      .io_en_in(io_space_en),       // [RULE11]
      .fwd_out(REQ_FWD_OUT),
      .ur_out(REQ_UR_OUT)
   );

   // upstream initiation only while bus mastering is on
   assign MST_GRANT_OUT = MST_REQ_IN && bus_master_en; // [RULE8]

   // ***************************************************************
   // error message reporting
   // ***************************************************************
   // either enable source lets messages out
   assign report_nonfatal = system_error_report_en
      || dev_ctrl[DC_NONFATAL_BIT]; // [RULE5] [RULE3]
   assign report_fatal = system_error_report_en
      || dev_ctrl[DC_FATAL_BIT];    // [RULE5] [RULE3]

   // secondary SERR maps to the nonfatal message only, only via the command bit
   always_ff @(posedge CLK_SYS_IN) begin
      if (!NRST_IN) begin
         ERR_NONFATAL_OUT <= 1'b0;
         ERR_FATAL_OUT <= 1'b0;
      end else begin
         ERR_NONFATAL_OUT <= (report_nonfatal && OWN_NONFATAL_IN)
            || (system_error_report_en && SEC_SERR_IN); // [RULE4]
         ERR_FATAL_OUT <= report_fatal && OWN_FATAL_IN;  // [RULE3]
      end
   end

   // ***************************************************************
   // interrupt status, one sticky bit per event
   // ***************************************************************
   assign ev_set[EV_MDPE] = parity_response_en
      && (POISON_CPL_IN || POISON_WR_IN);
   assign ev_set[EV_UR] = REQ_UR_OUT;
   assign ev_set[EV_ERR_MSG] = ERR_NONFATAL_OUT || ERR_FATAL_OUT;
   genvar gi;
   generate
      for (gi = 0; gi < EV_COUNT; gi++) begin : g_ev
         bcc_w1c_bit u_ev (
            .clk_in(CLK_SYS_IN),
            .nrst_in(NRST_IN),
            .set_in(ev_set[gi]),
            .clr_in(wr_acc && PADDR_IN == IRQ_STATUS_OFS && PWDATA_IN[gi]),
            .flag_out(irq_stat[gi])
         );
      end
   endgenerate
   assign IRQ_OUT = |(irq_stat & irq_mask);

   // ***************************************************************
   // read mux
   // ***************************************************************
   always_comb begin
      cmd_word = ZERO_WORD;
      cmd_word[IO_SPACE_BIT] = io_space_en;
      cmd_word[MEM_SPACE_BIT] = memory_space_en;
      cmd_word[BUS_MASTER_BIT] = bus_master_en;
      cmd_word[SPECIAL_CYC_BIT] = special_cycle_en;   // [RULE2]
      cmd_word[WR_INVAL_BIT] = write_invalidate_en;   // [RULE7]
      cmd_word[PALETTE_BIT] = palette_snoop;          // [RULE2]
      cmd_word[PARITY_RESP_BIT] = parity_response_en;
      cmd_word[WAIT_CYC_BIT] = wait_cycle_en;         // [RULE2]
      cmd_word[SYS_ERR_BIT] = system_error_report_en;
      cmd_word[FAST_B2B_BIT] = fast_b2b_enable;       // [RULE2]
      cmd_word[IRQ_DIS_BIT] = irq_disable_bit;        // [RULE1]
      cmd_word[MDPE_BIT] = master_data_parity_error;  // [RULE16]
   end

   always_comb begin
      next_rdata = ZERO_WORD;
      hit = 1'b1;
      if (PADDR_IN == CMD_STATUS_OFS) begin
         next_rdata = cmd_word;
      end else if (PADDR_IN == CLASS_CODE_OFS) begin
         // [RULE12] [RULE13] [RULE14] [RULE15] [RULE17]
         next_rdata = {BASE_CLASS, SUB_CLASS, INTERFACE_A, REVISION};
      end else if (PADDR_IN == DEV_CTRL_OFS) begin
         next_rdata = {29'h0, dev_ctrl};
      end else if (PADDR_IN == IRQ_STATUS_OFS) begin
         next_rdata = {29'h0, irq_stat};
      end else if (PADDR_IN == IRQ_MASK_OFS) begin
         next_rdata = {29'h0, irq_mask};
      end else begin
         hit = 1'b0;
      end
   end

   // read data captured in setup so it is stable during access
   always_ff @(posedge CLK_SYS_IN) begin
      if (!NRST_IN) begin
         PRDATA_OUT <= ZERO_WORD;
      end else if (rd_acc) begin
         PRDATA_OUT <= next_rdata;
      end
   end

   // unmapped addresses answer with an error, writes dropped
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_poison;
      parity_response_en && (POISON_CPL_IN || POISON_WR_IN);
   endsequence
   // frozen enable stays low, then the promotion output stays low
   sequence s_inval_kept;
      !cmd_word[WR_INVAL_BIT] ##1 !WR_INVAL_OUT;
   endsequence

   a_mdpe_set_gated: assert property (@(posedge CLK_SYS_IN) // [RULE16]
      disable iff (!NRST_IN)
      s_poison |=> master_data_parity_error)
      else $error("parity flag not set after poison");
   // a rise of the flag needs the enable in the cycle before it
   a_mdpe_no_set: assert property (@(posedge CLK_SYS_IN) // [RULE6]
      disable iff (!NRST_IN)
      !parity_response_en |=> !$rose(master_data_parity_error))
      else $error("parity flag set while response disabled");
   a_zero_bits: assert property (@(posedge CLK_SYS_IN) // [RULE1] [RULE2]
      disable iff (!NRST_IN)
      !cmd_word[IRQ_DIS_BIT] && !cmd_word[FAST_B2B_BIT]
      && !cmd_word[WAIT_CYC_BIT] && !cmd_word[PALETTE_BIT]
      && !cmd_word[SPECIAL_CYC_BIT])
      else $error("fixed command bits not zero");
   a_class_word: assert property (@(posedge CLK_SYS_IN) // [RULE12] [RULE13]
      disable iff (!NRST_IN)
      rd_acc && PADDR_IN == CLASS_CODE_OFS
      |=> PRDATA_OUT[31:8] == {BASE_CLASS, SUB_CLASS, INTERFACE_A})
      else $error("class code read wrong");
   a_mem_ur: assert property (@(posedge CLK_SYS_IN) // [RULE9]
      disable iff (!NRST_IN)
      REQ_VALID_IN && REQ_KIND_IN == BCC_REQ_MEM && !memory_space_en
      |=> REQ_UR_OUT && !REQ_FWD_OUT)
      else $error("memory request not refused");
   a_mem_fwd: assert property (@(posedge CLK_SYS_IN) // [RULE10]
      disable iff (!NRST_IN)
      REQ_VALID_IN && REQ_KIND_IN == BCC_REQ_MEM && memory_space_en
      |=> REQ_FWD_OUT && !REQ_UR_OUT)
      else $error("memory request not forwarded");
   a_io_gate: assert property (@(posedge CLK_SYS_IN) // [RULE11]
      disable iff (!NRST_IN)
      REQ_VALID_IN && REQ_KIND_IN == BCC_REQ_IO
      |=> REQ_UR_OUT == !$past(io_space_en))
      else $error("io request handling wrong");
   a_master_gate: assert property (@(posedge CLK_SYS_IN) // [RULE8]
      disable iff (!NRST_IN)
      MST_GRANT_OUT |-> bus_master_en)
      else $error("grant without bus master enable");
   a_serr_fwd: assert property (@(posedge CLK_SYS_IN) // [RULE4]
      disable iff (!NRST_IN)
      SEC_SERR_IN && system_error_report_en |=> ERR_NONFATAL_OUT)
      else $error("secondary error not reported");
   a_err_quiet: assert property (@(posedge CLK_SYS_IN) // [RULE5] [RULE3]
      disable iff (!NRST_IN)
      !system_error_report_en && dev_ctrl == 3'h0
      |=> !ERR_FATAL_OUT && !ERR_NONFATAL_OUT)
      else $error("error message while reporting off");
   a_ro_write: assert property (@(posedge CLK_SYS_IN) // [RULE17] [RULE7]
      disable iff (!NRST_IN)
      wr_acc && PADDR_IN == CMD_STATUS_OFS |=> s_inval_kept)
      else $error("read-only bit took a write");
endmodule : bcc_regs

//--- hw/bcc_req_gate.sv
// request gate: decides forward or unsupported from the space enables
module bcc_req_gate
   import bcc_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic valid_in,
   input wire bcc_req_kind_t kind_in,
   input wire logic mem_en_in,
   input wire logic io_en_in,
   output logic fwd_out,
   output logic ur_out
);
   logic next_fwd;
   logic next_ur;
   // memory and io requests are refused while their enable is clear
   always_comb begin
      next_fwd = 1'b0;
      next_ur = 1'b0;
      if (valid_in) begin
         case (kind_in)
            BCC_REQ_MEM: begin
               next_fwd = mem_en_in;
               next_ur = !mem_en_in;
            end
            BCC_REQ_IO: begin
               next_fwd = io_en_in;
               next_ur = !io_en_in;
            end
            default: begin
               next_fwd = 1'b1;
            end
         endcase
      end
   end
   // registered one-cycle verdict
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         fwd_out <= 1'b0;
         ur_out <= 1'b0;
      end else begin
         fwd_out <= next_fwd;
         ur_out <= next_ur;
      end
   end
endmodule : bcc_req_gate

//--- hw/bcc_w1c_bit.sv
// sticky status flag: set by hardware, cleared by writing one
module bcc_w1c_bit (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic set_in,
   input wire logic clr_in,
   output logic flag_out
);
   // set wins over clear so an event in the clear cycle is kept
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         flag_out <= 1'b1;
      end else if (clr_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule : bcc_w1c_bit

//--- tb/bcc_rc_model.sv
// root complex stand-in: issues link requests to the bridge one at a time
module bcc_rc_model
   import bcc_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic issue_in,
   input wire bcc_req_kind_t kind_in,
   output logic req_valid_out,
   output bcc_req_kind_t req_kind_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // one-cycle request; the kind wobbles while idle so that a gate which
   // ignores valid sees a moving kind instead of a friendly stale one
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         req_valid_out <= 1'b0;
         req_kind_out <= BCC_REQ_MEM;
      end else begin
         req_valid_out <= issue_in;
         if (issue_in) begin
            req_kind_out <= kind_in;
         end else if (req_kind_out == BCC_REQ_MEM) begin
            req_kind_out <= BCC_REQ_IO;
         end else begin
            req_kind_out <= BCC_REQ_MEM;
         end
      end
   end
endmodule : bcc_rc_model

//--- tb/bridge_command_class_regs_tb.sv
// self-checking bench of the command/class register bank
module bridge_command_class_regs_tb
   import bcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // stimulus and wiring
   // ***************************************************************
   localparam logic [7:0] REV = 8'h3C; // arbitrary revision for this run
   localparam logic [31:0] RW_MASK = 32'h0000_0147;
   localparam logic [31:0] CLASS_EXP = {8'h06, 8'h04, 8'h00, REV};
   logic CLK_SYS_IN = 1'b0;
   logic NRST_IN = 1'b0;
   logic PSEL_IN = 1'b0;
   logic PENABLE_IN = 1'b0;
   logic PWRITE_IN = 1'b0;
   logic [11:0] PADDR_IN = 12'h000;
   logic [31:0] PWDATA_IN = 32'h0000_0000;
   logic [31:0] PRDATA_OUT;
   logic PREADY_OUT, PSLVERR_OUT, REQ_FWD_OUT, REQ_UR_OUT;
   logic ERR_NONFATAL_OUT, ERR_FATAL_OUT, MST_GRANT_OUT;
   logic WR_INVAL_OUT, IRQ_OUT, req_valid;
   logic MST_REQ_IN = 1'b0;
   logic issue = 1'b0;
   logic [4:0] ev = 5'h00; // poison cpl, poison wr, nonfatal, fatal, serr
   bcc_req_kind_t kind = BCC_REQ_OTHER;
   bcc_req_kind_t req_kind;
   logic [31:0] rd, d;
   logic err;
   int n_errors = 0;
   int compares = 0;

   // clock: 200 MHz
   always #2.5 CLK_SYS_IN = ~CLK_SYS_IN;

   bcc_rc_model rc_u (.clk_in(CLK_SYS_IN), .nrst_in(NRST_IN),
      .issue_in(issue), .kind_in(kind), .req_valid_out(req_valid),
      .req_kind_out(req_kind));

   bcc_regs #(.REVISION(REV)) dut_u (.CLK_SYS_IN(CLK_SYS_IN),
      .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
      .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
      .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
      .PSLVERR_OUT(PSLVERR_OUT), .REQ_VALID_IN(req_valid),
      .REQ_KIND_IN(req_kind), .REQ_FWD_OUT(REQ_FWD_OUT),
      .REQ_UR_OUT(REQ_UR_OUT), .POISON_CPL_IN(ev[0]),
      .POISON_WR_IN(ev[1]), .OWN_NONFATAL_IN(ev[2]),
      .OWN_FATAL_IN(ev[3]), .SEC_SERR_IN(ev[4]),
      .ERR_NONFATAL_OUT(ERR_NONFATAL_OUT), .ERR_FATAL_OUT(ERR_FATAL_OUT),
      .MST_REQ_IN(MST_REQ_IN), .MST_GRANT_OUT(MST_GRANT_OUT),
      .WR_INVAL_OUT(WR_INVAL_OUT), .IRQ_OUT(IRQ_OUT));
   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // every driving task syncs to an edge first, so no signal is set twice at once
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge CLK_SYS_IN);
      PSEL_IN <= 1'b1;
      PENABLE_IN <= 1'b0;
      PWRITE_IN <= wr;
      PADDR_IN <= a;
      PWDATA_IN <= wd;
      @(posedge CLK_SYS_IN);
      PENABLE_IN <= 1'b1;
      do @(posedge CLK_SYS_IN); while (PREADY_OUT !== 1'b1);
      rd = PRDATA_OUT;
      err = PSLVERR_OUT;
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
      #1;
   endtask : apb

   task automatic rchk(input string name, input logic [11:0] a,
                       input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(name, exp, rd);
   endtask : rchk

   // one-cycle event pulse; the registered answers are settled on return
   task automatic fire(input int e);
      @(posedge CLK_SYS_IN);
      ev <= 5'h01 << e;
      @(posedge CLK_SYS_IN);
      ev <= 5'h00;
      #1;
   endtask : fire

   task automatic send(input int k);
      @(posedge CLK_SYS_IN);
      issue <= 1'b1;
      kind <= bcc_req_kind_t'(k[1:0]);
      @(posedge CLK_SYS_IN);
      issue <= 1'b0;
      @(posedge CLK_SYS_IN);
      #1;
   endtask : send

   // {fatal, nonfatal} message for one error event under enables i
   function automatic logic [1:0] exp_err(input int i, input int e);
      logic nf, f;
      nf = (e == 2 && (i[0] || i[1])) || (e == 4 && i[0]);
      f = e == 3 && (i[0] || i[2]);
      return {f, nf};
   endfunction : exp_err

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      #(20000 * 5);
      n_errors++;
      $display("mismatch watchdog expected finish seen hang");
      test_done();
   end
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      void'($urandom(32'h526A));
      repeat (3) @(posedge CLK_SYS_IN);
      NRST_IN <= 1'b1;
      rchk("cmd reset", CMD_STATUS_OFS, 32'h0000_0000);
      rchk("class", CLASS_CODE_OFS, CLASS_EXP);
      chk("class err", 32'h0, {31'h0, err});
      rchk("irq reset", IRQ_STATUS_OFS, 32'h0000_0000);
      apb(1'b1, CLASS_CODE_OFS, 32'hFFFF_FFFF);
      rchk("class ro", CLASS_CODE_OFS, CLASS_EXP);
      rchk("unmapped", 12'h00C, 32'h0000_0000);
      chk("unmapped err", 32'h1, {31'h0, err});
      // all-ones corner first, then random command words
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         apb(1'b1, CMD_STATUS_OFS, d);
         rchk("cmd rw", CMD_STATUS_OFS, d & RW_MASK);
         @(posedge CLK_SYS_IN);
         MST_REQ_IN <= d[31];
         #1;
         chk("grant", {31'h0, d[31]&d[2]}, {31'h0, MST_GRANT_OUT});
         chk("wr inval", 32'h0, {31'h0, WR_INVAL_OUT});
      end
      // every space enable pairing against every request kind
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, CMD_STATUS_OFS, m);
         for (int k = 0; k < 3; k++) begin
            send(k);
            d[0] = k == 2 || (k == 0 && m[1]) || (k == 1 && m[0]);
            chk("fwd", {31'h0, d[0]}, {31'h0, REQ_FWD_OUT});
            chk("ur", {31'h0, ~d[0]}, {31'h0, REQ_UR_OUT});
         end
      end
      // parity flag: gated, set by both poison kinds, cleared by one
      apb(1'b1, CMD_STATUS_OFS, 32'h0000_0000);
      fire(0);
      rchk("no parity", CMD_STATUS_OFS, 32'h0000_0000);
      apb(1'b1, CMD_STATUS_OFS, 32'h0000_0040);
      fire(0);
      rchk("parity cpl", CMD_STATUS_OFS, 32'h0100_0040);
      apb(1'b1, CMD_STATUS_OFS, 32'h0100_0040);
      rchk("parity clr", CMD_STATUS_OFS, 32'h0000_0040);
      fire(1);
      rchk("parity wr", CMD_STATUS_OFS, 32'h0100_0040);
      // error messages under every mix of enables
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, CMD_STATUS_OFS, i[0] ? 32'h0000_0100 : 32'h0);
         apb(1'b1, DEV_CTRL_OFS, {29'h0, i[2:1], 1'b0});
         for (int e = 2; e < 5; e++) begin
            fire(e);
            d = {30'h0, ERR_FATAL_OUT, ERR_NONFATAL_OUT};
            chk("err", {30'h0, exp_err(i, e)}, d);
         end
      end
      // interrupt: sticky status, mask, write-one clear
      rchk("irq status", IRQ_STATUS_OFS, 32'h0000_0007);
      chk("irq masked", 32'h0, {31'h0, IRQ_OUT});
      for (int b = 0; b < 3; b++) begin
         apb(1'b1, IRQ_MASK_OFS, 32'h1 << b);
         chk("irq on", 32'h1, {31'h0, IRQ_OUT});
      end
      apb(1'b1, IRQ_STATUS_OFS, 32'h0000_0007);
      chk("irq off", 32'h0, {31'h0, IRQ_OUT});
      rchk("irq clr", IRQ_STATUS_OFS, 32'h0000_0000);
      test_done();
   end
endmodule : bridge_command_class_regs_tb
